// ===== dv/testbench.sv
// Self-checking bench for the arithmetic execute slice.
// Assumes the slice is reached only over its Wishbone port and its FLAGS and BUSY outputs; operands are
// loaded into registers by running operations and into memory by MEMA writes.
`timescale 1ns/100ps
`include "aacf_cfg.svh"
module testbench
   import aacf_pkg::*;
();
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we  = 1'b0;
   logic [5:2]  adr = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] dout;
   logic        ack;
   logic        busy;
   logic [7:0]  flags;
   logic [31:0] seed = 32'h44;
   int          bad_count = 0;
   int          comparisons = 0;

   aacf_alu DUT (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat),
      .WB_DAT_O(dout), .WB_ACK_O(ack), .BUSY(busy), .FLAGS(flags));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Reference for magnitude (k=0, source b) and add-with-carry (k=1)
   function automatic logic [39:0] iref(input logic k, input logic [31:0] a,
      input logic [31:0] b, input logic [7:0] f, input logic [4:0] d);
      logic [32:0] s;
      logic [31:0] r;
      logic        ov;
      logic [7:0]  n;
      n = f;
      if (k)
      begin
         s = {1'b0, a} + {1'b0, b} + {32'h0, f[0]};
         r = s[31:0];
         ov = (a[31] == b[31]) && (r[31] != a[31]);
         if (ov && f[7])
            r = a[31] ? `AACF_WORD_MIN : `AACF_WORD_MAX;
         n[0] = s[32];
         n[3] = r[31];
      end
      else
      begin
         ov = (b == `AACF_WORD_MIN);
         r = b[31] ? -b : b;
         if (ov)
            r = f[7] ? `AACF_WORD_MAX : b;
         n[3] = 1'b0;
      end
      n[1] = ov;
      n[2] = (r == 32'h0);
      n[4] = 1'b0;
      n[5] = f[5] | ov;
      if (d >= 5'd8)
         n = f;
      return {n, r};
   endfunction

   function automatic logic [31:0] cw(input logic [2:0] op,
      input logic [1:0] m, input logic [4:0] s1, input logic [4:0] s2,
      input logic [4:0] d, input logic [4:0] ss, input logic [4:0] sa);
      return {2'b10, sa, ss, d, s2, s1, m, op};
   endfunction

   task automatic test_done();
      $display("Comparisons %0d, errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   // Request held until ack is sampled high, then released for a cycle
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 40);
      q = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 40)
      begin
         bad_count++;
         test_done();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic go(input logic [31:0] c, input logic [31:0] imm);
      logic [31:0] s;
      int          n;
      wr(`AACF_OFS_OPA, imm);
      wr(`AACF_OFS_CTRL, c);
      n = 0;
      do
      begin
         wb(1'b0, `AACF_OFS_STAT, 32'h0, s);
         n++;
      end
      while ((s !== 32'h0 || busy !== 1'b0) && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         test_done();
      end
   endtask

   // Register load costs two operations: zero it, then add the value
   task automatic ldr(input logic [4:0] r, input logic [31:0] v);
      wr(`AACF_OFS_FLAGS, 32'h0);
      go(cw(AACF_OP_ABS, 2'h3, 5'h0, 5'h0, r, 5'h0, 5'h0), 32'h0);
      go(cw(AACF_OP_ADC, 2'h3, 5'h0, 5'h0, r, 5'h0, 5'h0), v);
   endtask

   task automatic ldm(input logic [4:0] a, input logic [31:0] v);
      wr(`AACF_OFS_MEMA, {27'h0, a});
      wr(`AACF_OFS_MEMA, v);
   endtask

   // Reads register (m=0) or memory (m=1) through R9, outside R0-R7
   task automatic rdx(input logic [1:0] m, input logic [4:0] i,
      output logic [31:0] q);
      ldr(5'd9, 32'h0);
      go(cw(AACF_OP_ADC, m, i, 5'h0, 5'd9, 5'h0, 5'h0), 32'h0);
      wb(1'b0, `AACF_OFS_RESULT, 32'h0, q);
   endtask

   task automatic res(input logic [39:0] e);
      logic [31:0] q;
      wb(1'b0, `AACF_OFS_RESULT, 32'h0, q);
      chk("result", e[31:0], q);
      chk("flags", 32'(e[39:32]), 32'(flags));
   endtask

   initial
   begin
      logic [31:0] a, b, p, q, x, y;
      logic [7:0]  f;
      logic [4:0]  d;
      logic [1:0]  m;
      logic [39:0] e;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk("reset flags", 32'h0, {24'h0, flags});
      chk("reset busy", 32'h0, {31'h0, busy});
      wr(4'h8, `AACF_WORD_MAX);
      wb(1'b0, 4'h8, 32'h0, q);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 16; i++)
      begin
         m = i[2:1];
         a = xs();
         b = (i < 4) ? `AACF_WORD_MIN : xs();
         f = 8'(xs());
         f[7] = i[1];
         d = 5'(xs());
         d = {1'b0, d[3:0]};
         if (d == 5'd9)
            d = 5'd10;
         if (m == 2'h1 || m == 2'h2)
            b = b | `AACF_WORD_MIN;
         ldr(d, a);
         if (m == 2'h0)
            ldr(5'd20, b);
         else
            ldm(5'd3, b);
         wr(`AACF_OFS_FLAGS, {24'h0, f});
         go(cw(i[0] ? AACF_OP_ADC : AACF_OP_ABS, m, (m == 2'h0) ? 5'd20
            : 5'd3, 5'h0, d, 5'h0, 5'h0), b);
         e = iref(i[0], a, b, f, d);
         res(e);
         rdx(2'h0, d, q);
         chk("dst reg", e[31:0], q);
      end
      for (int i = 0; i < 4; i++)
      begin
         m = i[1:0];
         x = xs();
         y = xs();
         p = xs() | `AACF_WORD_MIN;
         q = xs() | `AACF_WORD_MIN;
         f = 8'(xs());
         ldr(5'd2, x);
         ldr(5'd5, y);
         ldm(5'd2, p);
         ldm(5'd5, q);
         wr(`AACF_OFS_FLAGS, {24'h0, f});
         go(cw(AACF_OP_ADC3, m, 5'd2, (m == 2'h3) ? 5'd2 : 5'd5, 5'd4,
            5'h0, 5'h0), 32'h0);
         a = m[0] ? p : x;
         b = m[1] ? (m[0] ? p : q) : y;
         res(iref(1'b1, a, b, f, 5'd4));
      end
      // Store source equals the arithmetic destination, and the store
      // address equals the indirect source address
      p = xs() | `AACF_WORD_MIN;
      x = xs();
      f = 8'(xs());
      ldm(5'd6, p);
      ldr(5'd4, x);
      wr(`AACF_OFS_FLAGS, {24'h0, f});
      go(cw(AACF_OP_ABS_ST, 2'h2, 5'd6, 5'h0, 5'd4, 5'd4, 5'd6), 32'h0);
      e = iref(1'b0, 32'h0, p, f, 5'd4);
      res(e);
      rdx(2'h1, 5'd6, q);
      chk("stored word", x, q);
      rdx(2'h0, 5'd4, q);
      chk("pair dst", e[31:0], q);
      ldr(5'd1, 32'h7f000000);
      ldr(5'd3, 32'h7f000000);
      wr(`AACF_OFS_FLAGS, 32'h01);
      go(cw(AACF_OP_FADD3, 2'h0, 5'd1, 5'd3, 5'd5, 5'h0, 5'h0), 32'h0);
      chk("fovf flags", 32'h23, {24'h0, flags});
      ldr(5'd2, 32'h01000000);
      wr(`AACF_OFS_FLAGS, 32'h81);
      go(cw(AACF_OP_FADD3, 2'h0, 5'd2, 5'd2, 5'd6, 5'h0, 5'h0), 32'h0);
      wb(1'b0, `AACF_OFS_RESULT, 32'h0, q);
      chk("fsum", 32'h02000000, q);
      chk("fsum flags", 32'h81, {24'h0, flags});
      wr(`AACF_OFS_FLAGS, 32'h01);
      go(cw(AACF_OP_FADD_ST, 2'h0, 5'd2, 5'd2, 5'd2, 5'd2, 5'd7), 32'h0);
      wb(1'b0, `AACF_OFS_RESULT, 32'h0, q);
      chk("fsum pair", 32'h02000000, q);
      chk("fpair flags", 32'h01, {24'h0, flags});
      rdx(2'h1, 5'd7, q);
      chk("fstore", 32'h01000000, q);
      test_done();
   end
endmodule // testbench

// ===== hdl/aacf_alu.sv
// Execute slice for magnitude, add-with-carry and float add, with a
// parallel store half. Wishbone classic slave on CORE_CLK.
// Function
// - Two-operand source mode 00 reg, 01 direct, 10 indirect, 11 immediate.
// - Three-operand mode: src1 indirect on bit0, src2 indirect on bit1.
// - Flags change only when destination is R0 through R7.
// - Two-operand add-with-carry: dst plus src plus carry into dst.
// - Three-operand add-with-carry: src1 plus src2 plus carry into dst.
// - Float add sums two sources; registers limited to R0 through R7; the code accepts any register.
// - Integer ops set latched overflow on overflow, else keep it.
// - Integer ops set overflow on overflow, else clear it.
// - Add-with-carry updates carry; magnitude and float add keep it.
// - Float add sets latched underflow and overflow, else keeps them.
// - Float add sets or clears underflow and overflow flags.
// - Integer results depend on the saturation mode bit.
// - Float add result ignores the saturation mode bit.
// - Parallel pair reads old registers, writes all at cycle end.
// - Same location: indirect source is read before the store.
// - Magnitude of most negative: overflow; saturate or pass unchanged.
`timescale 1ns/100ps
`include "aacf_cfg.svh"
module aacf_alu
   import aacf_pkg::*;
#(
   parameter int NREG  = 32,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [5:2]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Execution status
   output logic             BUSY,
   output logic [7:0]       FLAGS
);
   localparam int RW = $clog2(NREG);
   localparam int MW = $clog2(DEPTH);

   initial
   begin
      if (NREG > 32 || DEPTH > 32) $error("field widths exceeded");
   end

   // Control word: [2:0] op, [4:3] mode, [9:5] src1/src, [14:10] src2,
   // [19:15] dst, [24:20] store source reg, [29:25] store addr, [31] go
   logic [31:0]  ctrl_ff;
   logic [31:0]  opa_ff;
   logic [31:0]  result_ff;
   logic [31:0]  mema_ff;
   logic [7:0]   flags_ff;
   logic         ack_ff;
   logic [31:0]  rdat_ff;
   aacf_state_e  state_ff;
   logic         go_pend_ff;

   wire aacf_op_e   op   = aacf_op_e'(ctrl_ff[2:0]);
   wire logic [1:0] mode = ctrl_ff[4:3];
   wire logic [4:0] f_s1 = ctrl_ff[9:5];
   wire logic [4:0] f_s2 = ctrl_ff[14:10];
   wire logic [4:0] f_d  = ctrl_ff[19:15];
   wire logic [4:0] f_ss = ctrl_ff[24:20];
   wire logic [4:0] f_sa = ctrl_ff[29:25];

   wire logic bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
   wire logic bus_wr  = bus_req && WB_WE_I;

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // Regfile: port A reads src1 / dst, port B reads src2 / store source
   logic [31:0] rda;
   logic [31:0] rdb;
   logic        rf_we;
   logic [4:0]  rf_wa;
   logic [31:0] rf_wd;
   logic [31:0] mrd;
   logic        mem_we;

   // Two-operand adds read dst on port A and their source on port B
   wire logic [4:0] rf_ra = (op == AACF_OP_ADC) ? f_d : f_s1;
   wire logic [4:0] rf_rb = (op == AACF_OP_ABS_ST ||
                             op == AACF_OP_FADD_ST) ? f_ss :
                            (op == AACF_OP_ADC) ? f_s1 : f_s2;
   // Memory operand address: three-operand forms fetch src2 from memory
   // unless src1 is indirect too, when both share the src1 address
   wire logic [4:0] m_ra = ((op == AACF_OP_ADC3 || op == AACF_OP_FADD3 ||
                             op == AACF_OP_FADD_ST) && !mode[0]) ?
                           f_s2 : f_s1;

   aacf_regfile #(.NREG(NREG), .W(32)) u_rf
   (
      .clk (CORE_CLK),
      .rst (RST),
      .ra  (rf_ra[RW-1:0]),
      .rb  (rf_rb[RW-1:0]),
      .rda (rda),
      .rdb (rdb),
      .we  (rf_we),
      .wa  (rf_wa[RW-1:0]),
      .wd  (rf_wd)
   );

   aacf_opmem #(.DEPTH(DEPTH), .W(32)) u_mem
   (
      .clk   (CORE_CLK),
      .raddr (m_ra[MW-1:0]),
      .rdata (mrd),
      .we    (mem_we),
      .waddr (mem_we && state_ff != AACF_ST_EXEC ?
              mema_ff[MW-1:0] : f_sa[MW-1:0]),
      .wdata (mem_we && state_ff != AACF_ST_EXEC ? WB_DAT_I : rdb)
   );

   // Operand selection
   logic        is_three;
   logic [31:0] a_op;
   logic [31:0] b_op;
   always_comb
   begin
      is_three = (op == AACF_OP_ADC3 || op == AACF_OP_FADD3 ||
                  op == AACF_OP_FADD_ST);
      a_op = rda;
      b_op = rdb;
      if (is_three)
      begin
         a_op = mode[0] ? mrd : rda;
         b_op = mode[1] ? mrd : rdb;
      end
      else if (op == AACF_OP_ABS_ST)
      begin
         a_op = mrd;
      end
      else
      begin
         case (mode)
            `AACF_MODE_REG: b_op = (op == AACF_OP_ABS) ? rda : rdb;
            `AACF_MODE_DIR,
            `AACF_MODE_IND: b_op = mrd;
            `AACF_MODE_IMM: b_op = opa_ff;
            default:        b_op = rdb;
         endcase
         if (op == AACF_OP_ABS) a_op = b_op;
      end
   end

   // Integer datapath
   logic [32:0] isum;
   logic [31:0] ires;
   logic        iov;
   logic        icy;
   always_comb
   begin
      isum = {1'b0, a_op} + {1'b0, b_op} +
             {32'h0, flags_ff[`AACF_FL_C]};
      icy  = isum[32];
      iov  = (a_op[31] == b_op[31]) && (isum[31] != a_op[31]);
      ires = isum[31:0];
      if (iov && flags_ff[`AACF_FL_OVM])
      begin
         ires = a_op[31] ? `AACF_WORD_MIN : `AACF_WORD_MAX;
      end
   end

   logic [31:0] ares;
   logic        aov;
   always_comb
   begin
      aov  = (a_op == `AACF_WORD_MIN);
      ares = a_op[31] ? (~a_op + 32'h1) : a_op;
      if (aov)
      begin
         ares = flags_ff[`AACF_FL_OVM] ? `AACF_WORD_MAX : a_op;
      end
   end

   // Float add: [31:24] signed exponent, [23] sign, [22:0] fraction
   logic [31:0] fres;
   logic        fov;
   logic        fuf;
   logic        fzero;
   always_comb
   begin
      logic signed [8:0]  ea;
      logic signed [8:0]  eb;
      logic signed [8:0]  er;
      logic signed [26:0] ma;
      logic signed [26:0] mb;
      logic signed [26:0] ms;
      logic [8:0]         dsh;
      logic [26:0]        mag;
      dsh = 9'd0;
      er  = 9'sd0;
      ms  = 27'sd0;
      mag = 27'd0;
      ea = 9'(signed'(a_op[31:24]));
      eb = 9'(signed'(b_op[31:24]));
      ma = 27'(signed'({a_op[23], ~a_op[23], a_op[22:0]}));
      mb = 27'(signed'({b_op[23], ~b_op[23], b_op[22:0]}));
      if (ea >= eb)
      begin
         dsh = 9'(ea - eb);
         mb  = (dsh > 9'd26) ? 27'sd0 : (mb >>> dsh);
         er  = ea;
      end
      else
      begin
         dsh = 9'(eb - ea);
         ma  = (dsh > 9'd26) ? 27'sd0 : (ma >>> dsh);
         er  = eb;
      end
      ms  = ma + mb;
      mag = ms[26] ? 27'(-ms) : 27'(ms);
      if (mag[24])
      begin
         mag = mag >> 1;
         er  = er + 9'sd1;
      end
      else
      begin
         for (int k = 0; k < 24; k++)
         begin
            if (!mag[23] && mag != 27'd0)
            begin
               mag = mag << 1;
               er  = er - 9'sd1;
            end
         end
      end
      fzero = (mag == 27'd0);
      fov   = !fzero && (er > 9'(`AACF_FEXP_MAX));
      fuf   = !fzero && (er <= 9'(`AACF_FEXP_MIN));
      // Saturation mode bit is never consulted here
      if (fzero || fuf)
         fres = {`AACF_FEXP_MIN, 24'h0};
      else if (fov)
         fres = {`AACF_FEXP_MAX, ms[26], {23{~ms[26]}}};
      else
         fres = {er[7:0], ms[26], mag[22:0]};
   end

   // Flag and result resolution
   logic [31:0] res;
   logic [7:0]  nflags;
   always_comb
   begin
      res    = ires;
      nflags = flags_ff;
      case (op)
         AACF_OP_ABS, AACF_OP_ABS_ST:
         begin
            res = ares;
            nflags[`AACF_FL_N]  = 1'b0;
            nflags[`AACF_FL_V]  = aov;
            nflags[`AACF_FL_LV] = flags_ff[`AACF_FL_LV] | aov;
            nflags[`AACF_FL_UF] = 1'b0;
         end
         AACF_OP_ADC, AACF_OP_ADC3:
         begin
            nflags[`AACF_FL_N]  = ires[31];
            nflags[`AACF_FL_V]  = iov;
            nflags[`AACF_FL_LV] = flags_ff[`AACF_FL_LV] | iov;
            nflags[`AACF_FL_C]  = icy;
            nflags[`AACF_FL_UF] = 1'b0;
         end
         AACF_OP_FADD3, AACF_OP_FADD_ST:
         begin
            res = fres;
            nflags[`AACF_FL_N]   = fres[23] && !fzero && !fuf;
            nflags[`AACF_FL_V]   = fov;
            nflags[`AACF_FL_UF]  = fuf;
            nflags[`AACF_FL_LV]  = flags_ff[`AACF_FL_LV] | fov;
            nflags[`AACF_FL_LUF] = flags_ff[`AACF_FL_LUF] | fuf;
         end
         default: res = ires;
      endcase
      if (op == AACF_OP_FADD3 || op == AACF_OP_FADD_ST)
         nflags[`AACF_FL_Z] = fzero || fuf;
      else
         nflags[`AACF_FL_Z] = (res == 32'h0);
      if (f_d >= 5'(`AACF_EXT_REGS))
         nflags = flags_ff;
      nflags[`AACF_FL_OVM] = flags_ff[`AACF_FL_OVM];
   end

   // Sequencer: IDLE -> EXEC (operands registered) -> DONE
   wire logic go_wr = bus_wr && WB_ADR_I == `AACF_OFS_CTRL &&
                      WB_SEL_I[3] && WB_DAT_I[31];
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         state_ff <= AACF_ST_IDLE;
      else
         case (state_ff)
            AACF_ST_IDLE: if (go_pend_ff) state_ff <= AACF_ST_EXEC;
            AACF_ST_EXEC: state_ff <= AACF_ST_DONE;
            AACF_ST_DONE: state_ff <= AACF_ST_IDLE;
            default:      state_ff <= AACF_ST_IDLE;
         endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         go_pend_ff <= 1'b0;
      else
         go_pend_ff <= go_wr && state_ff == AACF_ST_IDLE;
   end

   // All writes land together at the end of the execute cycle
   assign rf_we  = (state_ff == AACF_ST_EXEC);
   assign rf_wa  = f_d;
   assign rf_wd  = res;
   // Store reads the old register and the memory port's old data
   // A MEMA write whose data has bit 31 set also stores that word at the
   // previous pointer; arming from the data means a pointer write never
   // scribbles on memory, but only such words can be loaded this way
   assign mem_we = (state_ff == AACF_ST_EXEC &&
                    (op == AACF_OP_ABS_ST || op == AACF_OP_FADD_ST)) ||
                   (bus_wr && WB_ADR_I == `AACF_OFS_MEMA &&
                    state_ff == AACF_ST_IDLE && WB_DAT_I[31]);

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         result_ff <= 32'h0;
      else if (state_ff == AACF_ST_EXEC)
         result_ff <= res;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         flags_ff <= 8'h0;
      else if (state_ff == AACF_ST_EXEC)
         flags_ff <= nflags;
      else if (bus_wr && WB_ADR_I == `AACF_OFS_FLAGS)
         flags_ff <= 8'(merge({24'h0, flags_ff}, WB_DAT_I, WB_SEL_I));
   end

   // Register writes from software
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ctrl_ff <= 32'h0;
         opa_ff  <= 32'h0;
         mema_ff <= 32'h0;
      end
      else if (bus_wr && state_ff == AACF_ST_IDLE)
      begin
         case (WB_ADR_I)
            `AACF_OFS_CTRL:
               ctrl_ff <= merge(ctrl_ff, WB_DAT_I, WB_SEL_I) &
                          32'h7fffffff;
            `AACF_OFS_OPA:  opa_ff  <= merge(opa_ff, WB_DAT_I, WB_SEL_I);
            `AACF_OFS_MEMA: mema_ff <= merge(mema_ff, WB_DAT_I, WB_SEL_I);
            default: ;
         endcase
      end
   end

   // Bus answer: registered ack after one wait state, dropped in the next
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0;
      end
      else
      begin
         ack_ff <= bus_req;
         case (WB_ADR_I)
            `AACF_OFS_CTRL:   rdat_ff <= ctrl_ff;
            `AACF_OFS_OPA:    rdat_ff <= opa_ff;
            `AACF_OFS_FLAGS:  rdat_ff <= {24'h0, flags_ff};
            `AACF_OFS_RESULT: rdat_ff <= result_ff;
            `AACF_OFS_MEMA:   rdat_ff <= mema_ff;
            `AACF_OFS_STAT:   rdat_ff <= {30'h0, state_ff};
            default:          rdat_ff <= 32'h0;
         endcase
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = rdat_ff;
   assign FLAGS    = flags_ff;
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         BUSY <= 1'b0;
      else
         BUSY <= go_wr || go_pend_ff || state_ff == AACF_ST_EXEC;
   end

   // Checks
   sequence s_exec_tail;
      state_ff == AACF_ST_DONE ##1 state_ff == AACF_ST_IDLE;
   endsequence

   a_flags_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && f_d >= 5'(`AACF_EXT_REGS)
      |=> flags_ff == $past(flags_ff))
      else $error("flags changed for high destination");
   a_lv_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && flags_ff[`AACF_FL_LV]
      |=> flags_ff[`AACF_FL_LV])
      else $error("latched overflow lost");
   a_abs_neg: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && f_d < 5'(`AACF_EXT_REGS) &&
      (op == AACF_OP_ABS || op == AACF_OP_ABS_ST)
      |=> !flags_ff[`AACF_FL_N])
      else $error("negative set by magnitude");
   a_fadd_carry: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && op inside {AACF_OP_FADD3,
      AACF_OP_FADD_ST, AACF_OP_ABS, AACF_OP_ABS_ST}
      |=> flags_ff[`AACF_FL_C] == $past(flags_ff[`AACF_FL_C]))
      else $error("carry touched");
   a_v_match: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && f_d < 5'(`AACF_EXT_REGS) &&
      op inside {AACF_OP_ADC, AACF_OP_ADC3}
      |=> flags_ff[`AACF_FL_V] == $past(iov))
      else $error("overflow flag wrong");
   a_one_cycle: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC |=> s_exec_tail)
      else $error("execute not single cycle");
   a_abs_sat: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && op == AACF_OP_ABS && aov
      |=> result_ff == ($past(flags_ff[`AACF_FL_OVM]) ?
          `AACF_WORD_MAX : `AACF_WORD_MIN))
      else $error("most negative magnitude wrong");
   a_uf_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_ff == AACF_ST_EXEC && f_d < 5'(`AACF_EXT_REGS) &&
      op inside {AACF_OP_ADC, AACF_OP_ADC3}
      |=> !flags_ff[`AACF_FL_UF] &&
          flags_ff[`AACF_FL_LUF] == $past(flags_ff[`AACF_FL_LUF]))
      else $error("underflow flags wrong");
endmodule // aacf_alu

// ===== hdl/aacf_cfg.svh
// Constants for the arithmetic execute slice: modes, flag bits, word limits,
// register map. Assumes inclusion by bare name from hdl/.
`ifndef AACF_CFG_SVH
`define AACF_CFG_SVH
`define AACF_OFS_CTRL   4'h0
`define AACF_OFS_OPA    4'h1
`define AACF_OFS_OPB    4'h2
`define AACF_OFS_DST    4'h3
`define AACF_OFS_FLAGS  4'h4
`define AACF_OFS_RESULT 4'h5
`define AACF_OFS_MEMA   4'h6
`define AACF_OFS_STAT   4'h7
`define AACF_MODE_REG   2'h0
`define AACF_MODE_DIR   2'h1
`define AACF_MODE_IND   2'h2
`define AACF_MODE_IMM   2'h3
`define AACF_FL_C       0
`define AACF_FL_V       1
`define AACF_FL_Z       2
`define AACF_FL_N       3
`define AACF_FL_UF      4
`define AACF_FL_LV      5
`define AACF_FL_LUF     6
`define AACF_FL_OVM     7
`define AACF_EXT_REGS   8
`define AACF_FEXP_MAX   8'sh7f
`define AACF_FEXP_MIN   8'sh80
`define AACF_WORD_MAX   32'h7fffffff
`define AACF_WORD_MIN   32'h80000000
`endif

// ===== hdl/aacf_opmem.sv
// Small operand memory standing in for the data-memory operand path.
// Read data registered; read and write in one cycle return old data.
`timescale 1ns/100ps
module aacf_opmem
#(
   parameter int DEPTH = 16,
   parameter int W     = 32
)
(
   // Clock
   input  wire logic                     clk,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [W-1:0]             rdata,
   // Write port
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [W-1:0]             wdata
);
   logic [W-1:0] mem_ff [DEPTH];

   initial
   begin
      if (DEPTH < 2) $error("DEPTH too small");
   end

   always_ff @(posedge clk)
   begin
      rdata <= mem_ff[raddr];
   end

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_ff[waddr] <= wdata;
      end
   end
endmodule // aacf_opmem

// ===== hdl/aacf_pkg.sv
// Types for the arithmetic execute slice.
// Assumes the constants header is compiled alongside.
package aacf_pkg;
   typedef enum logic [2:0]
   {
      AACF_OP_ABS    = 3'b000,
      AACF_OP_ABS_ST = 3'b001,
      AACF_OP_ADC    = 3'b010,
      AACF_OP_ADC3   = 3'b011,
      AACF_OP_FADD3  = 3'b100,
      AACF_OP_FADD_ST= 3'b101
   } aacf_op_e;
   typedef enum logic [1:0]
   {
      AACF_ST_IDLE  = 2'b00,
      AACF_ST_EXEC  = 2'b01,
      AACF_ST_DONE  = 2'b10
   } aacf_state_e;
endpackage

// ===== hdl/aacf_regfile.sv
// Register file of the slice: two read ports, one write port.
// Read data comes out of registers; write lands at the clock edge.
`timescale 1ns/100ps
module aacf_regfile
   import aacf_pkg::*;
#(
   parameter int NREG = 32,
   parameter int W    = 32
)
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Read ports
   input  wire logic [$clog2(NREG)-1:0] ra,
   input  wire logic [$clog2(NREG)-1:0] rb,
   output logic      [W-1:0]            rda,
   output logic      [W-1:0]            rdb,
   // Write port
   input  wire logic                    we,
   input  wire logic [$clog2(NREG)-1:0] wa,
   input  wire logic [W-1:0]            wd
);
   logic [W-1:0] mem_ff [NREG];

   initial
   begin
      if (NREG < `AACF_EXT_REGS) $error("NREG too small");
   end

   // Old contents are read: a write in the same edge is not seen here
   always_ff @(posedge clk)
   begin
      rda <= mem_ff[ra];
      rdb <= mem_ff[rb];
   end

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_ff[wa] <= wd;
      end
   end
endmodule // aacf_regfile
